// File: tlip_ctrl.sv
// two-level six-source interrupt controller with AXI4-Lite registers
// assumes peripheral event pulses on clk_sys; external pins are asynchronous
// Behaviour
// - six request sources served on two priority levels
// - one priority bit per source: clear is level 0, set is level 1
// - level of each source read from its priority bit at every decision
// - enabled pending request granted when nothing equal or higher is in service
// - request waits while equal or higher level runs, granted after it ends
// - level 1 preempts level 0; level 0 resumes after level 1 returns
// - same level ties: ext0, timer0, ext1, timer1, serial, timer2
// - fixed vectors 03H, 0BH, 13H, 1BH, 23H, 2BH per source
// - vectoring clears edge ext flags and timer0/1 flags; others stay set
// - transmit done set at bit 8 end in shift mode, else stop start
// - timer 2 external flag set on falling edge of its input when enabled
`default_nettype none

module tlip_ctrl (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext0_pin_n,
    input wire logic ext1_pin_n,
    input wire logic timer2_external_input,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic timer2_overflow,
    input wire logic serial_shift_mode,
    input wire logic serial_tx_bit8_end,
    input wire logic serial_tx_stop_start,
    input wire logic serial_rx_done,
    input wire logic core_ack,
    input wire logic core_reti,
    output tlip_pkg::tlip_grant_type grant,
    output logic irq
);

    logic [7:0] ie_q;
    logic [7:0] ip_q;
    logic [7:0] flag_en_q;
    logic [7:0] ctrl_q;
    logic [7:0] flags_q;
    logic [1:0] in_service_q;
    tlip_pkg::tlip_grant_type grant_q;
    logic irq_q;

    // pin synchronisers: ext0, ext1, timer 2 external
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_s3_q;
    logic [2:0] pin_filt_q;
    logic [2:0] pin_prev_q;
    logic [2:0] pin_fall;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_s1_q <= 3'h7;
            pin_s2_q <= 3'h7;
            pin_s3_q <= 3'h7;
            pin_filt_q <= 3'h7;
            pin_prev_q <= 3'h7;
        end else begin
            pin_s1_q <= {timer2_external_input, ext1_pin_n, ext0_pin_n};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_filt_q <= (~(pin_s2_q ^ pin_s3_q) & pin_s3_q)
                | ((pin_s2_q ^ pin_s3_q) & pin_filt_q);
            pin_prev_q <= pin_filt_q;
        end
    end

    assign pin_fall = pin_prev_q & ~pin_filt_q;

    // axi write channel
    logic aw_done_q;
    logic w_done_q;
    logic [7:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic wr_lane0_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_do;
    logic wr_hit;
    logic [7:0] sw_clr;

    assign wr_do = aw_done_q && w_done_q && !bvalid_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            awready_q <= 1'b0;
            aw_done_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (s_axi_awvalid && awready_q) begin
            awready_q <= 1'b0;
            aw_done_q <= 1'b1;
            wr_addr_q <= s_axi_awaddr;
        end else if (wr_do) begin
            aw_done_q <= 1'b0;
        end else if (!aw_done_q && !bvalid_q) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wready_q <= 1'b0;
            w_done_q <= 1'b0;
            wr_data_q <= 8'h00;
            wr_lane0_q <= 1'b0;
        end else if (s_axi_wvalid && wready_q) begin
            wready_q <= 1'b0;
            w_done_q <= 1'b1;
            wr_data_q <= s_axi_wdata[7:0];
            wr_lane0_q <= s_axi_wstrb[0];
        end else if (wr_do) begin
            w_done_q <= 1'b0;
        end else if (!w_done_q && !bvalid_q) begin
            wready_q <= 1'b1;
        end
    end

    always_comb begin
        wr_hit = 1'b1;
        sw_clr = 8'h00;
        if (wr_addr_q == tlip_pkg::ADDR_FLAG_CLR) begin
            sw_clr = (wr_do && wr_lane0_q) ? wr_data_q : 8'h00;
        end else if (wr_addr_q == tlip_pkg::ADDR_FLAG_EN) begin
            wr_hit = 1'b1;
        end else if (wr_addr_q == tlip_pkg::ADDR_CTRL) begin
            wr_hit = 1'b1;
        end else if (wr_addr_q == tlip_pkg::ADDR_IE) begin
            wr_hit = 1'b1;
        end else if (wr_addr_q == tlip_pkg::ADDR_IP) begin
            wr_hit = 1'b1;
        end else if (wr_addr_q == tlip_pkg::ADDR_FLAGS) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= tlip_pkg::RESP_OKAY;
        end else if (wr_do) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? tlip_pkg::RESP_OKAY : tlip_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // software registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ie_q <= tlip_pkg::IE_RESET;
            ip_q <= tlip_pkg::IP_RESET;
            flag_en_q <= tlip_pkg::FLAG_EN_RESET;
            ctrl_q <= tlip_pkg::CTRL_RESET;
        end else if (wr_do && wr_lane0_q) begin
            if (wr_addr_q == tlip_pkg::ADDR_IE) begin
                ie_q <= wr_data_q & tlip_pkg::IE_MASK;
            end else if (wr_addr_q == tlip_pkg::ADDR_IP) begin
                ip_q <= wr_data_q & tlip_pkg::IP_MASK;
            end else if (wr_addr_q == tlip_pkg::ADDR_FLAG_EN) begin
                flag_en_q <= wr_data_q;
            end else if (wr_addr_q == tlip_pkg::ADDR_CTRL) begin
                ctrl_q <= wr_data_q & tlip_pkg::CTRL_MASK;
            end
        end
    end

    // axi read channel
    logic arready_q;
    logic rvalid_q;
    logic [7:0] rdata_q;
    logic [1:0] rresp_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 8'h00;
            rresp_q <= tlip_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= tlip_pkg::RESP_OKAY;
            if (s_axi_araddr == tlip_pkg::ADDR_FLAGS) begin
                rdata_q <= flags_q;
            end else if (s_axi_araddr == tlip_pkg::ADDR_FLAG_CLR) begin
                rdata_q <= 8'h00;
            end else if (s_axi_araddr == tlip_pkg::ADDR_FLAG_EN) begin
                rdata_q <= flag_en_q;
            end else if (s_axi_araddr == tlip_pkg::ADDR_CTRL) begin
                rdata_q <= ctrl_q;
            end else if (s_axi_araddr == tlip_pkg::ADDR_IE) begin
                rdata_q <= ie_q;
            end else if (s_axi_araddr == tlip_pkg::ADDR_IP) begin
                rdata_q <= ip_q;
            end else begin
                rdata_q <= 8'h00;
                rresp_q <= tlip_pkg::RESP_SLVERR;
            end
        end else if (rvalid_q) begin
            if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end else begin
            arready_q <= 1'b1;
        end
    end

    // flag set and clear; set wins over clear
    logic [7:0] flag_set;
    logic [7:0] hw_clr;
    logic ack_take;

    assign ack_take = core_ack && grant_q.req;

    always_comb begin
        flag_set = 8'h00;
        flag_set[tlip_pkg::F_EXT0] = pin_fall[0];
        flag_set[tlip_pkg::F_TF0] = timer0_overflow;
        flag_set[tlip_pkg::F_EXT1] = pin_fall[1];
        flag_set[tlip_pkg::F_TF1] = timer1_overflow;
        flag_set[tlip_pkg::F_RX] = serial_rx_done;
        flag_set[tlip_pkg::F_TX] = serial_shift_mode ? serial_tx_bit8_end
            : serial_tx_stop_start;
        flag_set[tlip_pkg::F_TF2] = timer2_overflow;
        flag_set[tlip_pkg::F_TIMER2_EXTERNAL_FLAG] = pin_fall[2] && ctrl_q[tlip_pkg::CTRL_TIMER2_EXTERNAL_INPUT_EN];
        hw_clr = 8'h00;
        if (ack_take) begin
            hw_clr[tlip_pkg::F_EXT0] = grant_q.src == tlip_pkg::SRC_EXT0;
            hw_clr[tlip_pkg::F_TF0] = grant_q.src == tlip_pkg::SRC_TF0;
            hw_clr[tlip_pkg::F_EXT1] = grant_q.src == tlip_pkg::SRC_EXT1;
            hw_clr[tlip_pkg::F_TF1] = grant_q.src == tlip_pkg::SRC_TF1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flags_q <= 8'h00;
        end else begin
            flags_q <= flag_set | (flags_q & ~(hw_clr | sw_clr));
            if (!ctrl_q[tlip_pkg::CTRL_EXT0_EDGE]) begin
                flags_q[tlip_pkg::F_EXT0] <= ~pin_filt_q[0];
            end
            if (!ctrl_q[tlip_pkg::CTRL_EXT1_EDGE]) begin
                flags_q[tlip_pkg::F_EXT1] <= ~pin_filt_q[1];
            end
        end
    end

    // source requests, enables and priority pick
    logic [5:0] src_req;
    logic [5:0] pend;
    logic [5:0] cand;
    tlip_pkg::tlip_grant_type grant_d;

    always_comb begin
        src_req = {flags_q[tlip_pkg::F_TF2] | flags_q[tlip_pkg::F_TIMER2_EXTERNAL_FLAG],
            flags_q[tlip_pkg::F_RX] | flags_q[tlip_pkg::F_TX],
            flags_q[tlip_pkg::F_TF1], flags_q[tlip_pkg::F_EXT1],
            flags_q[tlip_pkg::F_TF0], flags_q[tlip_pkg::F_EXT0]};
        pend = src_req & ie_q[5:0] & {6{ie_q[tlip_pkg::IE_GLOBAL]}};
        grant_d = '0;
        cand = 6'h00;
        if (|(pend & ip_q[5:0]) && !in_service_q[1]) begin
            cand = pend & ip_q[5:0];
            grant_d.level = 1'b1;
        end else if (|(pend & ~ip_q[5:0]) && in_service_q == 2'h0) begin
            cand = pend & ~ip_q[5:0];
        end
        for (int i = tlip_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (cand[i]) begin
                grant_d.src = 3'(i);
            end
        end
        grant_d.req = |cand;
        grant_d.vector = tlip_pkg::VECTORS[grant_d.src];
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            grant_q <= '0;
        end else begin
            grant_q <= grant_d;
            if (ack_take) begin
                grant_q.req <= 1'b0;
            end
        end
    end

    // in-service levels, nested
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            in_service_q <= 2'h0;
        end else if (ack_take) begin
            in_service_q[grant_q.level] <= 1'b1;
        end else if (core_reti) begin
            if (in_service_q[1]) begin
                in_service_q[1] <= 1'b0;
            end else begin
                in_service_q[0] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_q & flag_en_q);
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = {24'h000000, rdata_q};
    assign grant = grant_q;
    assign irq = irq_q;

    // checking helpers
    logic [7:0] ip_prev_q;
    logic [5:0] cand_prev_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ip_prev_q <= 8'h00;
            cand_prev_q <= 6'h00;
        end else begin
            ip_prev_q <= ip_q;
            cand_prev_q <= cand;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    grant_level_a: assert property (grant_q.req |-> grant_q.level == ip_prev_q[grant_q.src])
        else $error("grant level differs from priority bit");
    vector_map_a: assert property (grant_q.req |-> grant_q.vector == {2'h0, grant_q.src, 3'h3})
        else $error("wrong vector for source");
    busy_hold_a: assert property ($past(in_service_q[1]) |-> !grant_q.req)
        else $error("grant while level 1 in service");
    preempt_only_a: assert property ((grant_q.req && $past(in_service_q[0])) |-> grant_q.level)
        else $error("level 0 grant during level 0 service");
    idle_grant_a: assert property ((|pend && in_service_q == 2'h0 && !core_ack) |=> grant_q.req)
        else $error("pending request not granted");
    global_off_a: assert property (!ie_q[tlip_pkg::IE_GLOBAL] |=> !grant_q.req)
        else $error("grant with global enable off");
    poll_order_a: assert property (grant_q.req |-> (cand_prev_q & ((6'h01 << grant_q.src) - 6'h01)) == 6'h00)
        else $error("lower polling source skipped");
    timer0_clear_a: assert property ((ack_take && grant_q.src == tlip_pkg::SRC_TF0 && !timer0_overflow) |=> !flags_q[tlip_pkg::F_TF0])
        else $error("timer 0 flag not cleared on vectoring");
    serial_keep_a: assert property ((ack_take && grant_q.src == tlip_pkg::SRC_SER && sw_clr == 8'h00) |=> ($past(flags_q[tlip_pkg::F_TX:tlip_pkg::F_RX]) & ~flags_q[tlip_pkg::F_TX:tlip_pkg::F_RX]) == 2'h0)
        else $error("serial flag cleared by vectoring");
    tx_set_a: assert property ((serial_shift_mode && serial_tx_bit8_end) |=> flags_q[tlip_pkg::F_TX])
        else $error("transmit done not set");
    timer2_external_flag_set_a: assert property ((pin_fall[2] && ctrl_q[tlip_pkg::CTRL_TIMER2_EXTERNAL_INPUT_EN]) |=> flags_q[tlip_pkg::F_TIMER2_EXTERNAL_FLAG])
        else $error("timer 2 external flag not set");

endmodule : tlip_ctrl

`default_nettype wire

// File: tlip_pkg.sv
// constants and types for the two-level interrupt priority controller
// assumes one 50 MHz core clock and an AXI4-Lite register port
`default_nettype none

package tlip_pkg;

    localparam int NUM_SRC = 6;
    localparam int ADDR_W = 8;

    // register byte addresses
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_FLAG_CLR = 8'h04;
    localparam logic [7:0] ADDR_FLAG_EN = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_IE = 8'hA8;
    localparam logic [7:0] ADDR_IP = 8'hB8;

    // reset values
    localparam logic [7:0] IE_RESET = 8'h00;
    localparam logic [7:0] IP_RESET = 8'h00;
    localparam logic [7:0] FLAG_EN_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // enable register fields and register write masks
    localparam int IE_GLOBAL = 7;
    localparam logic [7:0] IE_MASK = 8'hBF;
    localparam logic [7:0] IP_MASK = 8'h3F;
    localparam logic [7:0] CTRL_MASK = 8'h07;

    // control register fields
    localparam int CTRL_EXT0_EDGE = 0;
    localparam int CTRL_EXT1_EDGE = 1;
    localparam int CTRL_TIMER2_EXTERNAL_INPUT_EN = 2;

    // flag register fields
    localparam int F_EXT0 = 0;
    localparam int F_TF0 = 1;
    localparam int F_EXT1 = 2;
    localparam int F_TF1 = 3;
    localparam int F_RX = 4;
    localparam int F_TX = 5;
    localparam int F_TF2 = 6;
    localparam int F_TIMER2_EXTERNAL_FLAG = 7;

    // source numbers in polling order
    localparam logic [2:0] SRC_EXT0 = 3'h0;
    localparam logic [2:0] SRC_TF0 = 3'h1;
    localparam logic [2:0] SRC_EXT1 = 3'h2;
    localparam logic [2:0] SRC_TF1 = 3'h3;
    localparam logic [2:0] SRC_SER = 3'h4;
    localparam logic [2:0] SRC_TF2 = 3'h5;

    // vector address per source, index 5 first
    localparam logic [5:0][7:0] VECTORS = {8'h2B, 8'h23, 8'h1B, 8'h13, 8'h0B, 8'h03};

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic req;
        logic level;
        logic [2:0] src;
        logic [7:0] vector;
    } tlip_grant_type;

endpackage : tlip_pkg

`default_nettype wire

// File: tlip_core_model.sv
// partner model: processor core that takes grants and ends service routines
// assumes grant on clk_sys; one level 1 routine may nest on a level 0 one
`default_nettype none

module tlip_core_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [7:0] svc_len,
    input wire tlip_pkg::tlip_grant_type grant,
    output logic core_ack,
    output logic core_reti
);
    timeunit 1ns;
    timeprecision 1ps;

    // log of acks (bit 8 clear) and returns (bit 8 set) with vector
    logic [8:0] ev_q[$];
    logic [7:0] vec[2];
    int left[2];
    int depth;

    initial begin
        core_ack = 1'b0;
        core_reti = 1'b0;
        depth = 0;
    end

    always @(posedge clk_sys) begin
        core_ack <= 1'b0;
        core_reti <= 1'b0;
        if (sys_rst) begin
            depth = 0;
        end else if (depth > 0 && left[depth-1] <= 1) begin
            // innermost routine ends first
            depth = depth - 1;
            core_reti <= 1'b1;
            ev_q.push_back({1'b1, vec[depth]});
        end else begin
            if (depth > 0) begin
                left[depth-1] = left[depth-1] - 1;
            end
            if (run && grant.req === 1'b1 && !core_ack && !core_reti && depth < 2) begin
                vec[depth] = grant.vector;
                left[depth] = svc_len;
                depth = depth + 1;
                core_ack <= 1'b1;
                ev_q.push_back({1'b0, grant.vector});
            end
        end
    end

endmodule : tlip_core_model

`default_nettype wire

// File: two_level_interrupt_priority_tb.sv
// self-checking bench for the two-level interrupt controller
// assumes tlip_core_model as core; registers reached over AXI4-Lite
`default_nettype none

module two_level_interrupt_priority_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys, sys_rst, awv, wv, br, arv, rr, run, shm, e0n, e1n, t2x;
    logic awr, wrd, bv, arr, rvd, irq, ack, reti;
    logic [7:0] aw, ar, svc, ipr;
    logic [31:0] wd, rdat;
    logic [3:0] ws;
    logic [1:0] bresp, rresp;
    logic [5:0] ev;
    tlip_pkg::tlip_grant_type grant;
    int fail_count, n_tests, k;
    logic [8:0] exp_q[$];
    logic [7:0] regs[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'hA8, 8'hB8};

    tlip_ctrl uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvd), .s_axi_rready(rr), .ext0_pin_n(e0n),
        .ext1_pin_n(e1n), .timer2_external_input(t2x), .timer0_overflow(ev[0]),
        .timer1_overflow(ev[1]), .timer2_overflow(ev[2]), .serial_shift_mode(shm),
        .serial_tx_bit8_end(ev[3]), .serial_tx_stop_start(ev[4]), .serial_rx_done(ev[5]),
        .core_ack(ack), .core_reti(reti), .grant(grant), .irq(irq)
    );

    tlip_core_model core (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .run(run), .svc_len(svc), .grant(grant),
        .core_ack(ack), .core_reti(reti)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    task automatic tmo;
        fail_count++;
        $display("[FAIL] wait expected done seen timeout");
        final_report();
    endtask : tmo

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    task automatic pulse(input logic [5:0] m);
        ev <= m;
        @(posedge clk_sys);
        ev <= 6'h00;
    endtask : pulse

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        aw <= a;
        wd <= {24'h000000, d};
        ws <= 4'hF;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
            if (n > 200) tmo();
        end while (bv !== 1'b1);
        chk("bresp", bresp, er);
        br <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        ar <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (arv && arr) arv <= 1'b0;
            if (n > 200) tmo();
        end while (rvd !== 1'b1);
        chk("rdata", rdat, e);
        chk("rresp", rresp, er);
        rr <= 1'b0;
        @(posedge clk_sys);
    endtask : rdchk

    task automatic waitev(input int n);
        int c;
        c = 0;
        while (core.ev_q.size() < n || (n == 0 && core.depth != 0)) begin
            @(posedge clk_sys);
            c++;
            if (c > 2000) tmo();
        end
    endtask : waitev

    task automatic cmpev;
        foreach (exp_q[i]) chk("event", core.ev_q[i], exp_q[i]);
        exp_q.delete();
    endtask : cmpev

    initial begin
        sys_rst = 1'b1;
        {awv, wv, br, arv, rr, run, shm} = '0;
        {aw, ar, wd, ws, ev, svc} = '0;
        {e0n, e1n, t2x} = 3'h7;
        fail_count = 0;
        n_tests = 0;
        k = $urandom(32'hF963);
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        // reset values, unmapped place, masked bits
        foreach (regs[i]) rdchk(regs[i], 32'h0, tlip_pkg::RESP_OKAY);
        rdchk(8'h40, 32'h0, tlip_pkg::RESP_SLVERR);
        wr(8'h40, 8'hFF, tlip_pkg::RESP_SLVERR);
        wr(tlip_pkg::ADDR_IE, 8'hFF, tlip_pkg::RESP_OKAY);
        rdchk(tlip_pkg::ADDR_IE, 32'hBF, tlip_pkg::RESP_OKAY);
        ipr = 8'($urandom);
        wr(tlip_pkg::ADDR_IP, ipr, tlip_pkg::RESP_OKAY);
        rdchk(tlip_pkg::ADDR_IP, {24'h0, ipr & 8'h3F}, tlip_pkg::RESP_OKAY);
        wr(tlip_pkg::ADDR_IE, 8'h00, tlip_pkg::RESP_OKAY);
        wr(tlip_pkg::ADDR_IP, 8'h00, tlip_pkg::RESP_OKAY);
        // transmit done per serial mode, irq raise, mask, clear
        wr(tlip_pkg::ADDR_FLAG_EN, 8'h20, tlip_pkg::RESP_OKAY);
        for (k = 0; k < 2; k++) begin
            shm <= k[0];
            pulse(k[0] ? 6'h10 : 6'h08);
            cyc(3);
            rdchk(tlip_pkg::ADDR_FLAGS, 32'h00, tlip_pkg::RESP_OKAY);
            chk("irq", irq, 1'b0);
            pulse(k[0] ? 6'h08 : 6'h10);
            cyc(3);
            rdchk(tlip_pkg::ADDR_FLAGS, 32'h20, tlip_pkg::RESP_OKAY);
            chk("irq", irq, 1'b1);
            wr(tlip_pkg::ADDR_FLAG_EN, 8'h00, tlip_pkg::RESP_OKAY);
            cyc(2);
            chk("irq", irq, 1'b0);
            wr(tlip_pkg::ADDR_FLAG_EN, 8'h20, tlip_pkg::RESP_OKAY);
            cyc(2);
            chk("irq", irq, 1'b1);
            wr(tlip_pkg::ADDR_FLAG_CLR, 8'h20, tlip_pkg::RESP_OKAY);
            cyc(2);
            chk("irq", irq, 1'b0);
        end
        // timer 2 external input, disabled then enabled
        for (k = 0; k < 2; k++) begin
            wr(tlip_pkg::ADDR_CTRL, k[0] ? 8'h04 : 8'h00, tlip_pkg::RESP_OKAY);
            t2x <= 1'b0;
            cyc(8);
            rdchk(tlip_pkg::ADDR_FLAGS, k[0] ? 32'h80 : 32'h00, tlip_pkg::RESP_OKAY);
            t2x <= 1'b1;
            cyc(8);
        end
        // all six sources pending at level 0
        wr(tlip_pkg::ADDR_FLAG_CLR, 8'hFF, tlip_pkg::RESP_OKAY);
        wr(tlip_pkg::ADDR_CTRL, 8'h03, tlip_pkg::RESP_OKAY);
        wr(tlip_pkg::ADDR_IE, 8'hBF, tlip_pkg::RESP_OKAY);
        svc <= 8'h02;
        e0n <= 1'b0;
        e1n <= 1'b0;
        pulse(6'h27);
        cyc(8);
        run <= 1'b1;
        waitev(11);
        run <= 1'b0;
        for (k = 0; k < 5; k++) begin
            exp_q.push_back({1'b0, 8'(8'h03 + 8 * k)});
            exp_q.push_back({1'b1, 8'(8'h03 + 8 * k)});
        end
        exp_q.push_back(9'h023);
        cmpev();
        waitev(0);
        rdchk(tlip_pkg::ADDR_FLAGS, 32'h50, tlip_pkg::RESP_OKAY);
        e0n <= 1'b1;
        e1n <= 1'b1;
        wr(tlip_pkg::ADDR_FLAG_CLR, 8'hFF, tlip_pkg::RESP_OKAY);
        core.ev_q.delete();
        // global enable, then preemption and nesting
        wr(tlip_pkg::ADDR_IE, 8'h0A, tlip_pkg::RESP_OKAY);
        wr(tlip_pkg::ADDR_IP, 8'h08, tlip_pkg::RESP_OKAY);
        svc <= 8'(20 + $urandom_range(19));
        run <= 1'b1;
        pulse(6'h01);
        cyc(20);
        chk("events", core.ev_q.size(), 0);
        wr(tlip_pkg::ADDR_IE, 8'h8A, tlip_pkg::RESP_OKAY);
        waitev(1);
        cyc(5);
        pulse(6'h01);
        cyc(5);
        pulse(6'h02);
        waitev(6);
        exp_q = '{9'h00B, 9'h01B, 9'h11B, 9'h10B, 9'h00B, 9'h10B};
        cmpev();
        // level mode: ext0 flag follows its pin, clearing has no effect
        wr(tlip_pkg::ADDR_CTRL, 8'h00, tlip_pkg::RESP_OKAY);
        e0n <= 1'b0;
        cyc(8);
        wr(tlip_pkg::ADDR_FLAG_CLR, 8'h01, tlip_pkg::RESP_OKAY);
        rdchk(tlip_pkg::ADDR_FLAGS, 32'h01, tlip_pkg::RESP_OKAY);
        e0n <= 1'b1;
        cyc(8);
        rdchk(tlip_pkg::ADDR_FLAGS, 32'h00, tlip_pkg::RESP_OKAY);
        final_report();
    end

endmodule : two_level_interrupt_priority_tb

`default_nettype wire
